/* File: hw/eoms_pkg.sv */
// package: constants and carriers for the even/odd memory selector
//=====================================================================
// Overview of operation
// - two independent 16,384-word units, each started only by its own select pulse
// - even reference pulses even select, odd reference pulses odd, both when both needed
// - unit requests and address lines gated at 6(D2) for the processor, at 1(D2) for channels
// - processor selects at 7(D1); channel selects at A2(D1) of 12-point cycle
// - channels have priority; processor selection waits until channels leave B/E time
// - fourteen address bits pick the word, the fifteenth picks the unit
// - normal mode: bit 17 picks unit, 0 even, 1 odd
// - diagnostic mode: bit 3 picks unit, lower half even, upper half odd
// - address bus loads from counter, address reg, backup reg, channel, index adders
// - source gating drives bits 4-16; bit 3 driven separately with mode swap
// - bits 3,17: 00 even; 10 odd diag/even normal; 01 even diag/odd normal
// - bits 3,17 both one select the odd unit in either mode
// - diagnostic mode blocks index adders onto the bus; no same-unit double fetch
`default_nettype none
package eoms_pkg;
    //=================================================================
    // widths and sizes
    localparam int ADDR_W = 15;           // address bits 3..17, [14]=bit 3, [0]=bit 17
    localparam int WORD_W = 14;
    localparam int UNIT_WORDS = 16384;
    localparam int CPU_PT_W = 3;
    localparam int CHAN_PT_W = 4;
    //=================================================================
    // clock points
    localparam logic [2:0] CPU_GATE_PT = 3'h6;
    localparam logic [2:0] CPU_SEL_PT = 3'h7;
    localparam logic [3:0] CHAN_GATE_PT = 4'h1;
    localparam logic [3:0] CHAN_SEL_PT = 4'h2;
    //=================================================================
    // source one-hot positions
    localparam int SRC_ICNT = 0;
    localparam int SRC_OPND = 1;
    localparam int SRC_BKUP = 2;
    localparam int SRC_XAD = 3;
    localparam int SRC_N = 4;
    //=================================================================
    // reset values
    localparam logic [13:0] WORD_RST = 14'h0000;
    localparam logic SEL_RST = 1'b0;
    //=================================================================
    typedef enum logic [1:0] {
        EOMS_IDLE = 2'b00,
        EOMS_CPU_GATED = 2'b01,
        EOMS_CHAN_GATED = 2'b10
    } eoms_state_t;

    typedef struct packed {
        logic valid;
        logic [SRC_N-1:0] src;
        logic ovl;
    } eoms_cpu_req_t;

    typedef struct packed {
        logic sel;
        logic [WORD_W-1:0] word;
    } eoms_unit_t;
endpackage
`default_nettype wire

/* File: hw/eoms_select.sv */
// module: even/odd memory unit selector with address bus switching
`default_nettype none
module eoms_select (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [eoms_pkg::CPU_PT_W-1:0] cpu_point,
    input wire logic [eoms_pkg::CHAN_PT_W-1:0] chan_point,
    input wire logic phase_d2,
    input wire logic diag_mode_pin,
    input wire logic chan_busy,
    input wire eoms_pkg::eoms_cpu_req_t cpu_req,
    input wire logic chan_req,
    input wire logic [eoms_pkg::ADDR_W-1:0] instruction_counter,
    input wire logic [eoms_pkg::ADDR_W-1:0] operand_address_reg,
    input wire logic [eoms_pkg::ADDR_W-1:0] instruction_backup_reg,
    input wire logic [eoms_pkg::ADDR_W-1:0] chan_buffer_addr,
    input wire logic [eoms_pkg::ADDR_W-1:0] index_adder_sum,
    input wire logic [eoms_pkg::ADDR_W-1:0] index_adder_ovl,
    output logic cpu_taken,
    output logic ovl_taken,
    output logic chan_taken,
    output eoms_pkg::eoms_unit_t even_unit,
    output eoms_pkg::eoms_unit_t odd_unit,
    output logic [eoms_pkg::WORD_W-1:0] storage_address_latch
);
    //=================================================================
    // mode pin synchroniser
    logic diag_meta_ff;
    logic diag_ff;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            diag_meta_ff <= 1'b0;
            diag_ff <= 1'b0;
        end else begin
            diag_meta_ff <= diag_mode_pin;
            diag_ff <= diag_meta_ff;
        end
    end

    //=================================================================
    // address helpers
    // unit choice: diag uses bit 3, normal bit 17; table of four combos falls out
    function automatic logic unit_is_odd(input logic [eoms_pkg::ADDR_W-1:0] a,
                                         input logic diag);
        unit_is_odd = diag ? a[14] : a[0];
    endfunction

    // bit 3 slot carries bit 17 in diag mode, bits 4-16 pass straight
    function automatic logic [eoms_pkg::WORD_W-1:0] word_of(
            input logic [eoms_pkg::ADDR_W-1:0] a, input logic diag);
        word_of = {(diag ? a[0] : a[14]), a[13:1]};
    endfunction

    //=================================================================
    // source gating
    logic [eoms_pkg::SRC_N-1:0] src_gate;
    logic [eoms_pkg::ADDR_W-1:0] cpu_addr;
    always_comb begin
        src_gate = cpu_req.src;
        // index adder path has no logic in diag mode
        if (diag_ff) begin
            src_gate[eoms_pkg::SRC_XAD] = 1'b0;
        end
        cpu_addr = '0;
        // and-or bus: sources are one-hot, a stray second source just ors in
        if (src_gate[eoms_pkg::SRC_ICNT]) begin
            cpu_addr = cpu_addr | instruction_counter;
        end
        if (src_gate[eoms_pkg::SRC_OPND]) begin
            cpu_addr = cpu_addr | operand_address_reg;
        end
        if (src_gate[eoms_pkg::SRC_BKUP]) begin
            cpu_addr = cpu_addr | instruction_backup_reg;
        end
        if (src_gate[eoms_pkg::SRC_XAD]) begin
            cpu_addr = cpu_addr | index_adder_sum;
        end
    end

    //=================================================================
    // gating points
    logic at_cpu_gate;
    logic at_cpu_sel;
    logic at_chan_gate;
    logic at_chan_sel;
    assign at_cpu_gate = (cpu_point == eoms_pkg::CPU_GATE_PT) && phase_d2;
    assign at_cpu_sel = (cpu_point == eoms_pkg::CPU_SEL_PT) && !phase_d2;
    assign at_chan_gate = (chan_point == eoms_pkg::CHAN_GATE_PT) && phase_d2;
    assign at_chan_sel = (chan_point == eoms_pkg::CHAN_SEL_PT) && !phase_d2;

    //=================================================================
    // selector state
    eoms_pkg::eoms_state_t state_ff;
    eoms_pkg::eoms_state_t nxt_state;
    logic need_even_ff;
    logic nxt_need_even;
    logic need_odd_ff;
    logic nxt_need_odd;
    logic [eoms_pkg::WORD_W-1:0] even_word_ff;
    logic [eoms_pkg::WORD_W-1:0] nxt_even_word;
    logic [eoms_pkg::WORD_W-1:0] odd_word_ff;
    logic [eoms_pkg::WORD_W-1:0] nxt_odd_word;
    logic sel_even_ff;
    logic nxt_sel_even;
    logic sel_odd_ff;
    logic nxt_sel_odd;
    logic [eoms_pkg::WORD_W-1:0] latch_ff;
    logic [eoms_pkg::WORD_W-1:0] nxt_latch;

    logic prim_odd;
    logic ovl_odd;
    logic do_cpu;
    logic do_ovl;
    logic do_chan;
    logic any_src;

    always_comb begin
        nxt_state = state_ff;
        nxt_need_even = need_even_ff;
        nxt_need_odd = need_odd_ff;
        nxt_even_word = even_word_ff;
        nxt_odd_word = odd_word_ff;
        nxt_latch = latch_ff;
        nxt_sel_even = eoms_pkg::SEL_RST;
        nxt_sel_odd = eoms_pkg::SEL_RST;
        prim_odd = unit_is_odd(cpu_addr, diag_ff);
        ovl_odd = unit_is_odd(index_adder_ovl, diag_ff);
        any_src = |src_gate;
        do_chan = 1'b0;
        do_cpu = 1'b0;
        do_ovl = 1'b0;
        case (state_ff)
            eoms_pkg::EOMS_IDLE: begin
                // channel wins; a waiting channel also holds the processor off
                do_chan = chan_req && at_chan_gate;
                do_cpu = cpu_req.valid && any_src && at_cpu_gate && !do_chan
                    && !chan_busy && !chan_req;
                // second fetch only into the other unit, never in diag mode
                do_ovl = do_cpu && cpu_req.ovl && !diag_ff
                    && (ovl_odd != prim_odd);
                if (do_chan) begin
                    nxt_state = eoms_pkg::EOMS_CHAN_GATED;
                    nxt_need_even = !unit_is_odd(chan_buffer_addr, diag_ff);
                    nxt_need_odd = unit_is_odd(chan_buffer_addr, diag_ff);
                    nxt_latch = word_of(chan_buffer_addr, diag_ff);
                    if (unit_is_odd(chan_buffer_addr, diag_ff)) begin
                        nxt_odd_word = word_of(chan_buffer_addr, diag_ff);
                    end else begin
                        nxt_even_word = word_of(chan_buffer_addr, diag_ff);
                    end
                end else if (do_cpu) begin
                    nxt_state = eoms_pkg::EOMS_CPU_GATED;
                    nxt_need_even = !prim_odd || (do_ovl && !ovl_odd);
                    nxt_need_odd = prim_odd || (do_ovl && ovl_odd);
                    nxt_latch = word_of(cpu_addr, diag_ff);
                    if (prim_odd) begin
                        nxt_odd_word = word_of(cpu_addr, diag_ff);
                    end else begin
                        nxt_even_word = word_of(cpu_addr, diag_ff);
                    end
                    if (do_ovl && ovl_odd) begin
                        nxt_odd_word = word_of(index_adder_ovl, diag_ff);
                    end else if (do_ovl) begin
                        nxt_even_word = word_of(index_adder_ovl, diag_ff);
                    end
                end
            end
            eoms_pkg::EOMS_CPU_GATED: begin
                if (at_cpu_sel) begin
                    nxt_sel_even = need_even_ff;
                    nxt_sel_odd = need_odd_ff;
                    nxt_state = eoms_pkg::EOMS_IDLE;
                end
            end
            eoms_pkg::EOMS_CHAN_GATED: begin
                if (at_chan_sel) begin
                    nxt_sel_even = need_even_ff;
                    nxt_sel_odd = need_odd_ff;
                    nxt_state = eoms_pkg::EOMS_IDLE;
                end
            end
            default: begin
                nxt_state = eoms_pkg::EOMS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= eoms_pkg::EOMS_IDLE;
            need_even_ff <= 1'b0;
            need_odd_ff <= 1'b0;
            even_word_ff <= eoms_pkg::WORD_RST;
            odd_word_ff <= eoms_pkg::WORD_RST;
            latch_ff <= eoms_pkg::WORD_RST;
            sel_even_ff <= eoms_pkg::SEL_RST;
            sel_odd_ff <= eoms_pkg::SEL_RST;
        end else begin
            state_ff <= nxt_state;
            need_even_ff <= nxt_need_even;
            need_odd_ff <= nxt_need_odd;
            even_word_ff <= nxt_even_word;
            odd_word_ff <= nxt_odd_word;
            latch_ff <= nxt_latch;
            sel_even_ff <= nxt_sel_even;
            sel_odd_ff <= nxt_sel_odd;
        end
    end

    //=================================================================
    // outputs
    // takes are combinational so the requester may drop its request at once
    assign cpu_taken = do_cpu;
    assign ovl_taken = do_ovl;
    assign chan_taken = do_chan;
    assign even_unit = '{sel: sel_even_ff, word: even_word_ff};
    assign odd_unit = '{sel: sel_odd_ff, word: odd_word_ff};
    assign storage_address_latch = latch_ff;
endmodule
`default_nettype wire

/* File: verification/eoms_checker.sv */
// checker: timing and unit selection relations at the selector ports
`default_nettype none
module eoms_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [2:0] cpu_point,
    input wire logic [3:0] chan_point,
    input wire logic phase_d2,
    input wire logic diag_mode_pin,
    input wire logic chan_busy,
    input wire eoms_pkg::eoms_cpu_req_t cpu_req,
    input wire logic chan_req,
    input wire logic cpu_taken,
    input wire logic ovl_taken,
    input wire logic chan_taken,
    input wire eoms_pkg::eoms_unit_t even_unit,
    input wire eoms_pkg::eoms_unit_t odd_unit,
    input wire logic [13:0] storage_address_latch
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic sel_any = even_unit.sel | odd_unit.sel;
    wire logic no_take = !cpu_taken && !chan_taken;
    //==================================================================
    // gating and select moments
    sequence s_cpu_sel_pt;
        cpu_point == eoms_pkg::CPU_SEL_PT && !phase_d2;
    endsequence
    sequence s_chan_sel_pt;
        chan_point == eoms_pkg::CHAN_SEL_PT && !phase_d2;
    endsequence
    chk_cpu_gate_pt: assert property (cpu_taken |-> cpu_point == 3'h6 && phase_d2)
        else $error("processor reference gated off its point");
    chk_chan_first: assert property ((chan_req || chan_busy) |-> !cpu_taken)
        else $error("processor gated while a channel was active");
    chk_cpu_sel_time: assert property (cpu_taken ##1 s_cpu_sel_pt |=> sel_any)
        else $error("no select pulse after processor select point");
    chk_chan_sel_time: assert property (chan_taken ##1 s_chan_sel_pt |=> sel_any)
        else $error("no select pulse after channel select point");
    chk_sel_cause: assert property (sel_any |-> !$past(phase_d2) &&
        ($past(cpu_point) == 3'h7 || $past(chan_point) == 4'h2))
        else $error("select pulse at a wrong clock point");
    chk_sel_single: assert property (even_unit.sel || odd_unit.sel |=> !sel_any)
        else $error("select pulse longer than one cycle");
    chk_idle_units: assert property (no_take [*3] |-> !sel_any)
        else $error("select pulse without a reference");
    chk_latch_hold: assert property (no_take |=> $stable(storage_address_latch))
        else $error("address latch moved without a gated reference");
    chk_xad_block: assert property (cpu_req.src == 4'h8 && diag_mode_pin &&
        $past(diag_mode_pin, 2) |-> !cpu_taken && !ovl_taken)
        else $error("index adder gated in diagnostic mode");
endmodule
`default_nettype wire

/* File: verification/eoms_storage_model.sv */
// model: the even and odd storage units behind the select pulses
`default_nettype none
module eoms_storage_model (
    input wire logic sys_clk,
    input wire eoms_pkg::eoms_unit_t even_unit,
    input wire eoms_pkg::eoms_unit_t odd_unit,
    output logic [7:0] even_cnt,
    output logic [7:0] odd_cnt,
    output logic [13:0] even_word,
    output logic [13:0] odd_word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {even_cnt, odd_cnt, even_word, odd_word} = '0;
    // each unit starts only on its own pulse, word of 14 bits
    always @(posedge sys_clk) begin
        if (even_unit.sel) begin
            even_cnt <= even_cnt + 8'h01;
            even_word <= even_unit.word;
        end
        if (odd_unit.sel) begin
            odd_cnt <= odd_cnt + 8'h01;
            odd_word <= odd_unit.word;
        end
    end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// testbench: reference scenarios for the even/odd memory selector
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset = 1, phase_d2 = 0, diag_mode_pin = 0, chan_busy = 0, chan_req = 0;
    logic [2:0] cpu_point = '0;
    logic [3:0] chan_point = '0;
    eoms_pkg::eoms_cpu_req_t cpu_req = '0;
    logic [14:0] ctr_a = '0, opd_a = '0, bkp_a = '0, cba = '0, xs = '0, xo = '0;
    logic cpu_taken, ovl_taken, chan_taken;
    eoms_pkg::eoms_unit_t even_unit, odd_unit;
    logic [13:0] storage_address_latch, even_word, odd_word;
    logic [7:0] even_cnt, odd_cnt;
    int num_errors = 0, checks_done = 0;
    eoms_select dut (.sys_clk(sys_clk), .reset(reset), .cpu_point(cpu_point),
        .chan_point(chan_point), .phase_d2(phase_d2), .diag_mode_pin(diag_mode_pin),
        .chan_busy(chan_busy), .cpu_req(cpu_req), .chan_req(chan_req),
        .instruction_counter(ctr_a), .operand_address_reg(opd_a),
        .instruction_backup_reg(bkp_a),
        .chan_buffer_addr(cba), .index_adder_sum(xs), .index_adder_ovl(xo),
        .cpu_taken(cpu_taken), .ovl_taken(ovl_taken), .chan_taken(chan_taken),
        .even_unit(even_unit), .odd_unit(odd_unit),
        .storage_address_latch(storage_address_latch));
    eoms_storage_model u_mem (.sys_clk(sys_clk), .even_unit(even_unit), .odd_unit(odd_unit),
        .even_cnt(even_cnt), .odd_cnt(odd_cnt), .even_word(even_word), .odd_word(odd_word));
    always #5 sys_clk = ~sys_clk;
    // clock rings: one half point per cycle
    always @(negedge sys_clk) begin
        phase_d2 <= ~phase_d2;
        if (phase_d2) begin
            cpu_point <= cpu_point + 3'h1;
            chan_point <= (chan_point == 4'hb) ? 4'h0 : chan_point + 4'h1;
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic set_mode(input logic d);
        @(negedge sys_clk);
        diag_mode_pin = d;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic cpu_ref(input int s, input logic [14:0] a, input logic ov, input logic tk);
        logic d, pu, seen, ovx, ovs;
        logic [7:0] e0, o0;
        logic [13:0] w;
        d = diag_mode_pin;
        e0 = even_cnt;
        o0 = odd_cnt;
        seen = 1'b0;
        ovs = 1'b0;
        pu = d ? a[14] : a[0];
        // overlap address differs in bit 17 only: other unit in normal mode, refused in diag
        ovx = tk & ov & !d;
        w = {d ? a[0] : a[14], a[13:1]};
        @(negedge sys_clk);
        {ctr_a, opd_a, bkp_a, xs} = {4{~a}};
        case (s)
            0: ctr_a = a;
            1: opd_a = a;
            2: bkp_a = a;
            default: xs = a;
        endcase
        xo = a ^ 15'h0001;
        cpu_req = {1'b1, 4'(1 << s), ov};
        // takes are combinational: look once the ring has stepped, before the taking edge
        repeat (40) if (!seen) begin
            #1;
            seen = (cpu_taken === 1'b1);
            ovs = (ovl_taken === 1'b1);
            @(negedge sys_clk);
        end
        cpu_req.valid = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("taken", 16'(tk), 16'(seen));
        chk("overlap taken", 16'(ovx), 16'(ovs));
        chk("even pulses", 16'(e0 + (tk & (!pu | ovx))), 16'(even_cnt));
        chk("odd pulses", 16'(o0 + (tk & (pu | ovx))), 16'(odd_cnt));
        if (tk) begin
            chk("word", 16'(w), 16'(pu ? odd_word : even_word));
            chk("latch", 16'(w), 16'(storage_address_latch));
        end
        if (ovx) begin
            chk("overlap word", 16'(w), 16'(pu ? even_word : odd_word));
        end
    endtask
    task automatic chan_first();
        logic seen, ch;
        logic [7:0] e0;
        seen = 1'b0;
        ch = 1'b0;
        e0 = even_cnt;
        @(negedge sys_clk);
        cba = 15'h0246;
        ctr_a = 15'h0001;
        {chan_busy, chan_req} = 2'b11;
        cpu_req = {1'b1, 4'h1, 1'b0};
        repeat (40) begin
            #1;
            seen |= (cpu_taken === 1'b1);
            ch |= (chan_taken === 1'b1);
            @(negedge sys_clk);
            // drop right after the taking edge, or it is gated again next ring
            if (ch) begin
                chan_req = 1'b0;
            end
        end
        cpu_req = '0;
        chan_busy = 1'b0;
        chk("cpu held off", 16'h0000, 16'(seen));
        chk("channel taken", 16'h0001, 16'(ch));
        chk("channel select", 16'(e0 + 8'h01), 16'(even_cnt));
        chk("channel word", 16'h0123, 16'(even_word));
        cpu_ref(0, 15'h0001, 1'b0, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        set_mode(1'b0);
        for (int i = 0; i < 4; i++) cpu_ref(i, {i[1], 13'h0a5c, i[0]}, 1'b0, 1'b1);
        cpu_ref(0, 15'h1234, 1'b1, 1'b1);
        set_mode(1'b1);
        for (int i = 0; i < 4; i++) cpu_ref(i % 3, {i[1], 13'h1c3a, i[0]}, 1'b0, 1'b1);
        cpu_ref(3, 15'h4001, 1'b0, 1'b0);
        set_mode(1'b0);
        chan_first();
        wrap_up();
    end
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule
bind eoms_select eoms_checker u_chk (.sys_clk(sys_clk), .reset(reset), .cpu_point(cpu_point),
    .chan_point(chan_point), .phase_d2(phase_d2), .diag_mode_pin(diag_mode_pin),
    .chan_busy(chan_busy), .cpu_req(cpu_req), .chan_req(chan_req), .cpu_taken(cpu_taken),
    .ovl_taken(ovl_taken), .chan_taken(chan_taken), .even_unit(even_unit),
    .odd_unit(odd_unit), .storage_address_latch(storage_address_latch));
`default_nettype wire
